// ### rtl/hsr_status_regs.sv
// hot-plug slot status register bank with serial read access
`timescale 1ns/1ps
`default_nettype none
module hsr_status_regs
  import hsr_pkg::*;
#(
  parameter int P_SW_RISE_CYC = SW_RISE_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // serial link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  input wire logic i_addr_sel,
  // control word and interrupt requests, system clock domain
  input wire logic [7:0] i_ctrl_word,
  input wire logic [1:0] i_slot_irq_req,
  output logic o_irq_n,
  // per-slot conditions, asynchronous, index 0 is slot A
  input wire logic [1:0] i_slot_en_active,
  input wire logic [1:0] i_out_uv,
  input wire logic [1:0] i_overload,
  input wire logic [1:0] i_slot_pwr_ok,
  input wire logic [1:0] i_main_fault,
  input wire logic i_slot_a_switch_input,
  input wire logic i_slot_b_switch_input,
  // shared conditions, asynchronous
  input wire logic i_in_uv,
  input wire logic i_thermal_sd,
  // slot A overload detail, asynchronous
  input wire logic [3:0] i_slot_a_rail_ovl,
  input wire logic i_slot_a_aux_standby_supply_input_ovl,
  input wire logic i_slot_a_aux_main_supply_path_ovl,
  input wire logic i_slot_a_aux_standby_sw_on,
  input wire logic i_slot_a_aux_main_sw_on
);

  localparam int SW_CNT_W = $clog2(P_SW_RISE_CYC + 1);
  localparam logic [SW_CNT_W-1:0] SW_CNT_MAX = SW_CNT_W'(P_SW_RISE_CYC);
  // idle link lines read high, so no false edge follows reset
  localparam logic [ASYNC_W-1:0] AS_IDLE = (ASYNC_W'(1) << AS_SCL) | (ASYNC_W'(1) << AS_SDA);

  // ==========================================================
  // input synchronisers
  logic [ASYNC_W-1:0] async_w;
  logic [ASYNC_W-1:0] as_s1_r;
  logic [ASYNC_W-1:0] as_s2_r;
  logic scl_d_r;
  logic sda_d_r;

  assign async_w = {i_scl, i_sda, i_addr_sel, i_slot_a_aux_main_sw_on,
                    i_slot_a_aux_standby_sw_on, i_slot_a_aux_main_supply_path_ovl,
                    i_slot_a_aux_standby_supply_input_ovl, i_slot_a_rail_ovl,
                    i_thermal_sd, i_in_uv, i_main_fault, i_slot_pwr_ok,
                    i_slot_b_switch_input, i_slot_a_switch_input,
                    i_overload, i_out_uv, i_slot_en_active};

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      as_s1_r <= AS_IDLE;
      as_s2_r <= AS_IDLE;
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      as_s1_r <= async_w;
      as_s2_r <= as_s1_r;
      scl_d_r <= as_s2_r[AS_SCL];
      sda_d_r <= as_s2_r[AS_SDA];
    end
  end

  wire [1:0] as_en_w = as_s2_r[AS_EN +: 2];
  wire [1:0] as_out_uv_w = as_s2_r[AS_OUT_UV +: 2];
  wire [1:0] as_ovl_w = as_s2_r[AS_OVL +: 2];
  wire [1:0] as_sw_w = as_s2_r[AS_SW +: 2];
  wire [1:0] as_pwr_ok_w = as_s2_r[AS_PWR_OK +: 2];
  wire [1:0] as_main_flt_w = as_s2_r[AS_MAIN_FLT +: 2];
  wire scl_s_w = as_s2_r[AS_SCL];
  wire sda_s_w = as_s2_r[AS_SDA];

  // ==========================================================
  // switch input qualification
  logic [SW_CNT_W-1:0] sw_cnt_r [2];
  logic [1:0] sw_deb_w;

  for (genvar s = 0; s < 2; s++) begin : g_sw
    // rise must persist for the full delay, fall passes straight through
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sw_cnt_r[s] <= '0;
      end else if (!as_sw_w[s]) begin
        sw_cnt_r[s] <= '0;
      end else if (sw_cnt_r[s] != SW_CNT_MAX) begin
        sw_cnt_r[s] <= sw_cnt_r[s] + SW_CNT_W'(1);
      end
    end
    assign sw_deb_w[s] = (sw_cnt_r[s] == SW_CNT_MAX) && as_sw_w[s];
  end

  // ==========================================================
  // register images
  logic [7:0] ctrl_rb_w;
  logic [7:0] sta_w [2];
  logic [7:0] ovl_a_w;
  logic [7:0] rd_val_w;

  assign ctrl_rb_w[CTRL_MASK_A] = i_ctrl_word[CTRL_MASK_A];
  assign ctrl_rb_w[CTRL_MASK_B] = i_ctrl_word[CTRL_MASK_B];
  assign ctrl_rb_w[CTRL_EN_A] = as_en_w[0];
  assign ctrl_rb_w[CTRL_EN_B] = as_en_w[1];
  assign ctrl_rb_w[CTRL_SW_RST] = i_ctrl_word[CTRL_SW_RST];
  assign ctrl_rb_w[CTRL_SPARE_MSB:CTRL_SPARE_LSB] =
    i_ctrl_word[CTRL_SPARE_MSB:CTRL_SPARE_LSB];

  for (genvar s = 0; s < 2; s++) begin : g_sta
    // same layout for both slots
    assign sta_w[s][STA_EN] = as_en_w[s];
    assign sta_w[s][STA_IN_UV] = as_s2_r[AS_IN_UV];
    assign sta_w[s][STA_OUT_UV] = as_out_uv_w[s];
    assign sta_w[s][STA_OVL] = as_ovl_w[s];
    assign sta_w[s][STA_THERM] = as_s2_r[AS_THERM];
    assign sta_w[s][STA_SW] = sw_deb_w[s];
    assign sta_w[s][STA_PWR_OK] = as_pwr_ok_w[s];
    assign sta_w[s][STA_MAIN_FLT] = as_main_flt_w[s];
  end

  assign ovl_a_w[OVL_RAIL_MSB:OVL_RAIL_LSB] = as_s2_r[AS_RAIL +: 4];
  assign ovl_a_w[OVL_AUX_STBY] = as_s2_r[AS_AUX_OVL];
  assign ovl_a_w[OVL_AUX_MAIN] = as_s2_r[AS_AUX_OVL + 1];
  assign ovl_a_w[OVL_STBY_SW_ON] = as_s2_r[AS_AUX_SW];
  assign ovl_a_w[OVL_MAIN_SW_ON] = as_s2_r[AS_AUX_SW + 1];

  // ==========================================================
  // serial clock domain capture
  hsr_lnk_if lnk ();

  hsr_bit_capture u_cap (
    .i_scl(i_scl),
    .i_rst_n(i_rst_n),
    .i_sda(i_sda),
    .lnk(lnk)
  );

  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_s1_r <= 1'h0;
      tgl_s2_r <= 1'h0;
      tgl_d_r <= 1'h0;
    end else begin
      tgl_s1_r <= lnk.rx_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r <= tgl_s2_r;
    end
  end

  // ==========================================================
  // transfer engine
  hsr_state_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] idx_r;
  logic rw_r;
  logic ackph_r;
  logic sda_oe_n_r;
  logic irq_n_r;

  wire start_w = scl_s_w && scl_d_r && sda_d_r && !sda_s_w;
  wire stop_w = scl_s_w && scl_d_r && !sda_d_r && sda_s_w;
  wire scl_fall_w = !scl_s_w && scl_d_r;
  wire bit_evt_w = tgl_s2_r ^ tgl_d_r;
  wire at_ack_w = (cnt_r == ACK_SLOT);
  wire at_first_w = (cnt_r == BIT_FIRST);
  wire [6:0] dev_addr_w = {DEV_ADDR_HI, as_s2_r[AS_ADDR]};
  wire addr_hit_w = (sh_r[7:1] == dev_addr_w);
  wire busy_w = (st_r != ST_IDLE) && !start_w && !stop_w;
  wire tx_load_w = busy_w && !bit_evt_w && scl_fall_w && at_first_w &&
                   ((ackph_r && st_r == ST_ADDR && rw_r) || st_r == ST_TX);

  // sampled at load time only, so the byte never tears mid-shift
  assign rd_val_w = (idx_r == IDX_CTRL_RB) ? ctrl_rb_w :
                    (idx_r == IDX_STA_A) ? sta_w[0] :
                    (idx_r == IDX_OVL_A) ? ovl_a_w :
                    (idx_r == IDX_STA_B) ? sta_w[1] : RD_UNMAPPED;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= BIT_FIRST;
      sh_r <= '0;
      tx_r <= '0;
      idx_r <= '0;
      rw_r <= 1'h0;
      ackph_r <= 1'h0;
      sda_oe_n_r <= 1'h1;
    end else if (start_w || stop_w) begin
      st_r <= start_w ? ST_ADDR : ST_IDLE;
      cnt_r <= BIT_FIRST;
      ackph_r <= 1'h0;
      sda_oe_n_r <= 1'h1;
    end else if (st_r == ST_IDLE) begin
      cnt_r <= BIT_FIRST;
    end else if (bit_evt_w) begin
      if (!at_ack_w) begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[6:0], lnk.rx_bit};
        tx_r <= {tx_r[6:0], 1'h0};
      end else begin
        cnt_r <= BIT_FIRST;
        if (st_r == ST_TX && lnk.rx_bit) begin
          st_r <= ST_IDLE;
        end
      end
    end else if (scl_fall_w) begin
      if (tx_load_w) begin
        st_r <= ST_TX;
        ackph_r <= 1'h0;
        tx_r <= rd_val_w;
        sda_oe_n_r <= rd_val_w[7];
      end else if (ackph_r && at_first_w) begin
        ackph_r <= 1'h0;
        sda_oe_n_r <= 1'h1;
        st_r <= (st_r == ST_ADDR) ? ST_INDEX : ST_WDATA;
      end else if (at_ack_w && !ackph_r) begin
        if (st_r == ST_TX) begin
          sda_oe_n_r <= 1'h1;
        end else if (st_r == ST_ADDR && !addr_hit_w) begin
          st_r <= ST_IDLE;
        end else begin
          ackph_r <= 1'h1;
          sda_oe_n_r <= 1'h0;
          if (st_r == ST_ADDR) begin
            rw_r <= sh_r[0];
          end
          if (st_r == ST_INDEX) begin
            idx_r <= sh_r;
          end
        end
      end else if (st_r == ST_TX) begin
        sda_oe_n_r <= tx_r[7];
      end
    end
  end

  // ==========================================================
  // interrupt pin
  // masks act here only; status bits keep reporting regardless
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_n_r <= 1'h1;
    end else begin
      irq_n_r <= ~|(i_slot_irq_req & {i_ctrl_word[CTRL_MASK_B],
                                      i_ctrl_word[CTRL_MASK_A]});
    end
  end

  assign o_irq_n = irq_n_r;
  assign o_sda_oe_n = sda_oe_n_r;
  assign o_sda_o = 1'h0;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  wire ld_ctrl_w = tx_load_w && idx_r == IDX_CTRL_RB;

  property p_ctrl_mask;
    ld_ctrl_w |=> tx_r[CTRL_MASK_A] == $past(i_ctrl_word[CTRL_MASK_A]) &&
                  tx_r[CTRL_MASK_B] == $past(i_ctrl_word[CTRL_MASK_B]);
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("mask readback wrong");

  property p_ctrl_en;
    ld_ctrl_w |=> tx_r[CTRL_EN_A] == $past(as_en_w[0]) && tx_r[CTRL_EN_B] == $past(as_en_w[1]);
  endproperty
  a_ctrl_en: assert property (p_ctrl_en) else $error("enable readback wrong");

  property p_ctrl_upper;
    ld_ctrl_w |=> tx_r[CTRL_SPARE_MSB:CTRL_SW_RST] ==
                  $past(i_ctrl_word[CTRL_SPARE_MSB:CTRL_SW_RST]);
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("upper readback wrong");

  property p_sta_a;
    tx_load_w && idx_r == IDX_STA_A |=> tx_r == $past(sta_w[0]) && !o_sda_oe_n == !tx_r[7];
  endproperty
  a_sta_a: assert property (p_sta_a) else $error("slot A status byte wrong");

  property p_sta_b;
    tx_load_w && idx_r == IDX_STA_B |=> tx_r == $past(sta_w[1]);
  endproperty
  a_sta_b: assert property (p_sta_b) else $error("slot B status byte wrong");

  property p_ovl_a;
    tx_load_w && idx_r == IDX_OVL_A |=> tx_r == $past(ovl_a_w);
  endproperty
  a_ovl_a: assert property (p_ovl_a) else $error("overload byte wrong");

  property p_sw_rise;
    $rose(sw_deb_w[0]) |-> $past(as_sw_w[0], 8) && $past(as_sw_w[0], 1);
  endproperty
  a_sw_rise: assert property (p_sw_rise) else $error("switch rose without delay");

  property p_sw_fall;
    !as_sw_w[1] |-> !sw_deb_w[1] ##1 (sw_cnt_r[1] == '0);
  endproperty
  a_sw_fall: assert property (p_sw_fall) else $error("switch fall delayed");

  property p_addr_ack;
    busy_w && !bit_evt_w && scl_fall_w && at_ack_w && !ackph_r && st_r == ST_ADDR &&
    addr_hit_w |=> !o_sda_oe_n && ackph_r;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_irq_mask;
    (i_slot_irq_req & {i_ctrl_word[CTRL_MASK_B], i_ctrl_word[CTRL_MASK_A]}) == 2'h0
      |=> o_irq_n;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request drove irq");

  property p_no_side_effect;
    st_r == ST_TX |=> $stable(idx_r);
  endproperty
  a_no_side_effect: assert property (p_no_side_effect) else $error("read moved index");

  c_rd_sta_b: cover property (tx_load_w && idx_r == IDX_STA_B);
  c_rd_ctrl: cover property (ld_ctrl_w);
  c_master_nack: cover property (st_r == ST_TX ##1 st_r == ST_IDLE);
  c_sw_qual: cover property ($rose(sw_deb_w[0]));

endmodule : hsr_status_regs
`default_nettype wire

// ### rtl/hsr_pkg.sv
// shared constants and types for the hot-plug slot status register bank
package hsr_pkg;

  // ==========================================================
  // register indices
  localparam logic [7:0] IDX_CTRL_RB = 8'h11;
  localparam logic [7:0] IDX_STA_A = 8'h12;
  localparam logic [7:0] IDX_OVL_A = 8'h13;
  localparam logic [7:0] IDX_STA_B = 8'h14;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // control readback fields
  localparam int CTRL_MASK_A = 0;
  localparam int CTRL_EN_A = 1;
  localparam int CTRL_MASK_B = 2;
  localparam int CTRL_EN_B = 3;
  localparam int CTRL_SW_RST = 4;
  localparam int CTRL_SPARE_LSB = 5;
  localparam int CTRL_SPARE_MSB = 7;

  // ==========================================================
  // slot status fields
  localparam int STA_EN = 0;
  localparam int STA_IN_UV = 1;
  localparam int STA_OUT_UV = 2;
  localparam int STA_OVL = 3;
  localparam int STA_THERM = 4;
  localparam int STA_SW = 5;
  localparam int STA_PWR_OK = 6;
  localparam int STA_MAIN_FLT = 7;

  // ==========================================================
  // overload register fields
  localparam int OVL_RAIL_LSB = 0;
  localparam int OVL_RAIL_MSB = 3;
  localparam int OVL_AUX_STBY = 4;
  localparam int OVL_AUX_MAIN = 5;
  localparam int OVL_STBY_SW_ON = 6;
  localparam int OVL_MAIN_SW_ON = 7;

  // ==========================================================
  // serial link
  localparam logic [5:0] DEV_ADDR_HI = 6'h10;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_MHZ = 200;
  localparam int SW_RISE_NS = 1000;
  localparam int SW_RISE_CYC = (SW_RISE_NS * CLK_FREQ_MHZ + 999) / 1000;

  // ==========================================================
  // asynchronous input vector layout
  localparam int AS_EN = 0;
  localparam int AS_OUT_UV = 2;
  localparam int AS_OVL = 4;
  localparam int AS_SW = 6;
  localparam int AS_PWR_OK = 8;
  localparam int AS_MAIN_FLT = 10;
  localparam int AS_IN_UV = 12;
  localparam int AS_THERM = 13;
  localparam int AS_RAIL = 14;
  localparam int AS_AUX_OVL = 18;
  localparam int AS_AUX_SW = 20;
  localparam int AS_ADDR = 22;
  localparam int AS_SDA = 23;
  localparam int AS_SCL = 24;
  localparam int ASYNC_W = 25;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WDATA,
    ST_TX
  } hsr_state_e;

endpackage : hsr_pkg

// ### rtl/hsr_lnk_if.sv
// received-bit carrier from the serial clock domain to the system clock domain
`timescale 1ns/1ps
`default_nettype none
interface hsr_lnk_if;
  logic rx_bit;
  logic rx_tgl;
  modport cap (output rx_bit, output rx_tgl);
  modport eng (input rx_bit, input rx_tgl);
endinterface : hsr_lnk_if
`default_nettype wire

// ### rtl/hsr_bit_capture.sv
// serial clock domain: captures each data bit and flags it with a toggle
`timescale 1ns/1ps
`default_nettype none
module hsr_bit_capture (
  // serial clock and reset
  input wire logic i_scl,
  input wire logic i_rst_n,
  // data line
  input wire logic i_sda,
  // towards the system domain
  hsr_lnk_if.cap lnk
);
  logic bit_r;
  logic tgl_r;

  // bit value is held until the next serial edge, long after the toggle lands
  always_ff @(posedge i_scl or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_r <= 1'h0;
      tgl_r <= 1'h0;
    end else begin
      bit_r <= i_sda;
      tgl_r <= ~tgl_r;
    end
  end

  assign lnk.rx_bit = bit_r;
  assign lnk.rx_tgl = tgl_r;
endmodule : hsr_bit_capture
`default_nettype wire

// ### verification/hsr_i2c_master.sv
// serial-link master model that reads the slot status register bank
`timescale 1ns/1ps
`default_nettype none
module hsr_i2c_master (
  // link base clock
  input wire logic i_clk_lnk,
  // resolved data line level
  input wire logic i_sda,
  // link drives, data is open-drain
  output logic o_scl,
  output logic o_sda_low
);
  // ==========================================================
  // bit timing
  // 20 base cycles of 6 ns keep each clock phase above 100 ns
  localparam int HALF = 20;
  logic rd_ack_phase;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    rd_ack_phase = 1'b0;
  end

  task automatic half_bit;
    repeat (HALF) @(posedge i_clk_lnk);
  endtask : half_bit

  // data moves only a short hold after the clock has fallen
  task automatic clk_bit(input logic b, output logic s);
    repeat (5) @(posedge i_clk_lnk);
    o_sda_low = ~b;
    half_bit();
    o_scl = 1'b1;
    half_bit();
    s = i_sda;
    o_scl = 1'b0;
  endtask : clk_bit

  // ==========================================================
  // framing
  task automatic start_cond;
    o_sda_low = 1'b0;
    half_bit();
    o_scl = 1'b1;
    half_bit();
    o_sda_low = 1'b1;
    half_bit();
    o_scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    repeat (5) @(posedge i_clk_lnk);
    o_sda_low = 1'b1;
    half_bit();
    o_scl = 1'b1;
    half_bit();
    o_sda_low = 1'b0;
    half_bit();
  endtask : stop_cond

  // mark flags the acknowledge clock of this byte for the bench
  task automatic send_byte(input logic [7:0] v, input logic mark, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], s);
    end
    rd_ack_phase = mark;
    clk_bit(1'b1, nak);
    rd_ack_phase = 1'b0;
  endtask : send_byte

  // ==========================================================
  // register read: write index, repeated start, read one byte
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] idx,
                          output logic [7:0] d, output logic [2:0] nak);
    logic s;
    d = 8'h00;
    nak = 3'b111;
    start_cond();
    send_byte({dev, 1'b0}, 1'b0, nak[0]);
    if (nak[0] === 1'b0) begin
      send_byte(idx, 1'b0, nak[1]);
      start_cond();
      send_byte({dev, 1'b1}, 1'b1, nak[2]);
      for (int i = 7; i >= 0; i--) begin
        clk_bit(1'b1, d[i]);
      end
      clk_bit(1'b1, s);
    end
    stop_cond();
  endtask : read_reg
endmodule : hsr_i2c_master
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the slot status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module testbench
  import hsr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic clk_lnk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, m_low, sda_o, sda_oe_n, irq_n;
  wire sda;
  logic addr_sel = 1'b0;
  logic in_uv = 1'b0;
  logic therm = 1'b0;
  logic [7:0] ctrl = 8'h00;
  logic [7:0] ovp = 8'h00;
  logic [1:0] irq_req = 2'h0, en = 2'h0, out_uv = 2'h0, ovl = 2'h0;
  logic [1:0] pwr_ok = 2'h0, mflt = 2'h0, sw = 2'h0;
  logic [6:0] dev = 7'h20;
  int fail_count = 0;
  int checks_done = 0;
  int flds[7] = '{0, 1, 2, 3, 4, 6, 7};

  always #2.5 clk_sys = ~clk_sys;
  always #3 clk_lnk = ~clk_lnk;
  // pulled-up wire: low when either party pulls
  assign sda = (sda_oe_n === 1'b0) ? (sda_o & ~m_low) : ~m_low;

  hsr_status_regs hsr_status_regs_i (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_addr_sel(addr_sel),
    .i_ctrl_word(ctrl), .i_slot_irq_req(irq_req), .o_irq_n(irq_n),
    .i_slot_en_active(en), .i_out_uv(out_uv), .i_overload(ovl),
    .i_slot_pwr_ok(pwr_ok), .i_main_fault(mflt),
    .i_slot_a_switch_input(sw[0]), .i_slot_b_switch_input(sw[1]),
    .i_in_uv(in_uv), .i_thermal_sd(therm), .i_slot_a_rail_ovl(ovp[3:0]),
    .i_slot_a_aux_standby_supply_input_ovl(ovp[4]),
    .i_slot_a_aux_main_supply_path_ovl(ovp[5]),
    .i_slot_a_aux_standby_sw_on(ovp[6]), .i_slot_a_aux_main_sw_on(ovp[7])
  );

  hsr_i2c_master hsr_i2c_master_i (
    .i_clk_lnk(clk_lnk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low)
  );

  // ==========================================================
  // tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic set_sta(input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_sys);
    en = {b[0], a[0]};
    in_uv = a[1] | b[1];
    out_uv = {b[2], a[2]};
    ovl = {b[3], a[3]};
    therm = a[4] | b[4];
    pwr_ok = {b[6], a[6]};
    mflt = {b[7], a[7]};
  endtask : set_sta

  // chg moves the switch inputs about one bit time before the byte is loaded
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic chg = 1'b0, input logic [1:0] swv = 2'h0);
    logic [7:0] d;
    logic [2:0] nak;
    fork
      hsr_i2c_master_i.read_reg(dev, idx, d, nak);
      if (chg) begin
        for (int n = 0; n < 4000 && hsr_i2c_master_i.rd_ack_phase !== 1'b1; n++) begin
          @(negedge clk_sys);
        end
        if (hsr_i2c_master_i.rd_ack_phase !== 1'b1) begin
          fail_count++;
          end_sim();
        end
        sw = swv;
      end
    join
    `CHK("acks", 3'b000, nak)
    `CHK("read data", exp, d)
  endtask : rd

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] a, b, d;
    logic [2:0] nak;
    repeat (5) @(negedge clk_sys);
    `CHK("sda enable in reset", 1'b1, sda_oe_n)
    `CHK("irq pin in reset", 1'b1, irq_n)
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      irq_req = i[1:0];
      ctrl = {5'h00, i[3], 1'b0, i[2]};
      @(negedge clk_sys);
      `CHK("irq pin", ~|(i[1:0] & i[3:2]), irq_n)
    end
    $display("test interrupt mask done");
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys);
      ctrl = i ? 8'h5a : 8'ha5;
      en = i ? 2'b01 : 2'b10;
      rd(IDX_CTRL_RB, {ctrl[7:4], en[1], ctrl[2], en[0], ctrl[0]});
    end
    $display("test control readback done");
    for (int i = 0; i < 7; i++) begin
      a = 8'h01 << flds[i];
      b = 8'h01 << flds[(i + 3) % 7];
      set_sta(a, b);
      rd(IDX_STA_A, a | ((a | b) & 8'h12));
      rd(IDX_STA_B, b | ((a | b) & 8'h12));
    end
    $display("test slot status done");
    set_sta(8'h00, 8'h00);
    rd(IDX_STA_A, 8'h00, 1'b1, 2'b11);
    rd(IDX_STA_B, 8'h20);
    rd(IDX_STA_A, 8'h20);
    rd(IDX_STA_A, 8'h00, 1'b1, 2'b10);
    rd(IDX_STA_B, 8'h20);
    rd(IDX_STA_B, 8'h00, 1'b1, 2'b00);
    $display("test switch input done");
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys);
      ovp = i ? 8'h5a : 8'ha5;
      rd(IDX_OVL_A, ovp);
    end
    $display("test overload flags done");
    rd(8'h15, RD_UNMAPPED);
    hsr_i2c_master_i.read_reg(7'h21, IDX_CTRL_RB, d, nak);
    `CHK("foreign address ack", 1'b1, nak[0])
    @(negedge clk_sys);
    addr_sel = 1'b1;
    dev = 7'h21;
    rd(IDX_CTRL_RB, {ctrl[7:4], en[1], ctrl[2], en[0], ctrl[0]});
    $display("test addressing done");
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
